/* File: rtl/dual_readout_pkg.sv */
// Shared constants and types for the dual-channel serial readout block.
package dual_readout_pkg;

    // ********************************************************************
    // Frame timing in serial clock falling edges.
    // ********************************************************************
    localparam logic [5:0] EDGES_PER_CONV = 6'd32;
    localparam logic [5:0] HOLD_EDGE      = 6'd4;
    localparam logic [5:0] A_FIRST_EDGE   = 6'd5;
    localparam logic [5:0] A_LAST_EDGE    = 6'd16;
    localparam logic [5:0] GAP_FIRST_EDGE = 6'd17;
    localparam logic [5:0] GAP_LAST_EDGE  = 6'd20;
    localparam logic [5:0] B_FIRST_EDGE   = 6'd21;
    localparam logic [5:0] FIRST_EDGE     = 6'd1;
    localparam logic [5:0] NO_EDGE        = 6'd0;

    // ********************************************************************
    // Result coding.
    // ********************************************************************
    localparam int                RAW_W    = 14;
    localparam int                CODE_W   = 12;
    localparam logic signed [14:0] CODE_MAX = 15'sh07FF;
    localparam logic signed [14:0] CODE_MIN = -15'sh0800;
    localparam logic signed [14:0] HALF_STEP = 15'sh0001;

    // ********************************************************************
    // Sample buffer.
    // ********************************************************************
    localparam int SAMPLE_W   = 2 * RAW_W;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic signed [RAW_W-1:0] chanA;
        logic signed [RAW_W-1:0] chanB;
    } raw_pair_s;

    typedef struct packed {
        logic signed [CODE_W-1:0] chanA;
        logic signed [CODE_W-1:0] chanB;
    } code_pair_s;

    typedef enum logic [1:0] {
        IDLE,
        ACQUIRE,
        CONVERT
    } frame_state_e;

endpackage : dual_readout_pkg

/* File: rtl/sample_fifo.sv */
// Parameterised valid/ready FIFO for the sample stream.
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0]      count_q, count_d;
    logic             notFull_q, notFull_d;
    logic             push, pop;

    // ********************************************************************
    // Pointer and level bookkeeping.
    // ********************************************************************
    always_comb begin
        push      = inValid && notFull_q;
        pop       = outReady && (count_q != '0);
        wrPtr_d   = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
        rdPtr_d   = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
        count_d   = count_q;
        if (push && !pop) begin
            count_d = (AW+1)'(count_q + 1'b1);
        end else if (pop && !push) begin
            count_d = (AW+1)'(count_q - 1'b1);
        end
        // Registered full flag keeps the ready output free of logic.
        notFull_d = (count_d != (AW+1)'(DEPTH));
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wrPtr_q   <= '0;
            rdPtr_q   <= '0;
            count_q   <= '0;
            notFull_q <= 1'b1;
        end else begin
            wrPtr_q   <= wrPtr_d;
            rdPtr_q   <= rdPtr_d;
            count_q   <= count_d;
            notFull_q <= notFull_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    assign inReady  = notFull_q;
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];

endmodule : sample_fifo

/* File: rtl/dual_sample_serial_readout.sv */
// Frame sequencing, sampling and serial result output of the dual converter.
//
// What this block does
// - One conversion of both channels takes exactly thirty-two serial clock cycles.
// - Each result bit leaves on a falling serial clock edge, most significant bit first.
// - Channel A result goes first, then four zero bits, then the channel B result.
// - The bits shifted out belong to the conversion in progress, with no pipeline delay.
// - With chip select still low after channel B, conversions follow back to back.
// - Both inputs are tracked during the first three serial clock cycles of a conversion.
// - Both inputs are held together on the fourth falling edge and then converted.
// - Each channel result is a 12-bit two's complement number.
// - An input of reference minus one and a half steps or more gives the positive full scale.
// - The most negative inputs give the negative full-scale code.
// - The result output is driven only while chip select is low, otherwise released.
// - Falling edges one to four send zeros and edges five to sixteen send channel A.
// - Raising chip select early abandons the conversion and releases the output.
// - A chip select fall while the serial clock is low counts as the first falling edge.
`timescale 1ns/100ps
module dual_sample_serial_readout (
    input  wire logic                                   core_clk,
    input  wire logic                                   srst,
    input  wire logic                                   csN,
    input  wire logic                                   sclk,
    input  wire logic signed [dual_readout_pkg::RAW_W-1:0] diff_input_chan_a,
    input  wire logic signed [dual_readout_pkg::RAW_W-1:0] diff_input_chan_b,
    input  wire logic                                   sampleValid,
    output logic                                        sampleReady,
    output logic                                        dout,
    output logic                                        doutOenN
);
    import dual_readout_pkg::*;

    // ********************************************************************
    // Pin synchronisers and edge detection.
    // ********************************************************************
    logic csS1_q, csS2_q, csS3_q;
    logic sclkS1_q, sclkS2_q, sclkS3_q;
    logic csFall, sclkFall, csHigh;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            csS1_q   <= 1'b1;
            csS2_q   <= 1'b1;
            csS3_q   <= 1'b1;
            sclkS1_q <= 1'b1;
            sclkS2_q <= 1'b1;
            sclkS3_q <= 1'b1;
        end else begin
            csS1_q   <= csN;
            csS2_q   <= csS1_q;
            csS3_q   <= csS2_q;
            sclkS1_q <= sclk;
            sclkS2_q <= sclkS1_q;
            sclkS3_q <= sclkS2_q;
        end
    end

    assign csFall   = csS3_q && !csS2_q;
    assign csHigh   = csS2_q;
    assign sclkFall = sclkS3_q && !sclkS2_q;

    // ********************************************************************
    // Sample buffer in front of the track stage.
    // ********************************************************************
    raw_pair_s fifoIn, fifoOut;
    logic      fifoOutValid, trackEn, fifoReady;

    assign fifoIn.chanA = diff_input_chan_a;
    assign fifoIn.chanB = diff_input_chan_b;

    sample_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_sample_fifo (
        .core_clk (core_clk),
        .srst     (srst),
        .inValid  (sampleValid),
        .inReady  (fifoReady),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (trackEn),
        .outData  (fifoOut)
    );

    // ********************************************************************
    // Quantiser: half-step input units to a clamped code.
    // ********************************************************************
    function automatic logic signed [CODE_W-1:0] quantise(
        input logic signed [RAW_W-1:0] raw
    );
        logic signed [14:0] rounded;
        rounded = (15'(raw) + HALF_STEP) >>> 1;
        if (rounded > CODE_MAX) begin
            rounded = CODE_MAX;
        end else if (15'(raw) <= (CODE_MIN <<< 1) + HALF_STEP) begin
            // The bottom code also takes its own upper transition point, so an input
            // sitting exactly there still reads as negative full scale.
            rounded = CODE_MIN;
        end
        return rounded[CODE_W-1:0];
    endfunction : quantise

    // ********************************************************************
    // Frame sequencer.
    // ********************************************************************
    frame_state_e state_q, state_d;
    logic [5:0]   edgeCnt_q, edgeCnt_d;
    raw_pair_s    track_q, track_d;
    code_pair_s   held_q, held_d;
    code_pair_s   codeNow;
    logic         dout_q, dout_d;
    logic         oenN_q, oenN_d;
    logic [5:0]   edgeInc;
    logic         bitNext;

    assign codeNow.chanA = quantise(track_q.chanA);
    assign codeNow.chanB = quantise(track_q.chanB);

    // Number of the next falling edge; the counter and the bit choice share it,
    // which keeps the two combinational processes free of a loop between them.
    assign edgeInc = (edgeCnt_q == EDGES_PER_CONV) ? FIRST_EDGE
                                                   : 6'(edgeCnt_q + 1'b1);

    // Tracking drains the buffer; outside acquisition it fills and stalls the source.
    assign trackEn = (state_q == ACQUIRE);

    always_comb begin
        state_d   = state_q;
        edgeCnt_d = edgeCnt_q;
        track_d   = (trackEn && fifoOutValid) ? fifoOut : track_q;
        held_d    = held_q;
        oenN_d    = oenN_q;
        dout_d    = dout_q;
        if (csHigh) begin
            state_d   = IDLE;
            edgeCnt_d = NO_EDGE;
            oenN_d    = 1'b1;
            dout_d    = 1'b0;
        end else if (state_q == IDLE) begin
            if (csFall) begin
                oenN_d    = 1'b0;
                dout_d    = 1'b0;
                state_d   = ACQUIRE;
                // A low clock at the chip select fall already counts as edge one.
                edgeCnt_d = sclkS2_q ? NO_EDGE : FIRST_EDGE;
            end
        end else if (sclkFall) begin
            edgeCnt_d = edgeInc;
            if (edgeCnt_d == HOLD_EDGE) begin
                held_d  = codeNow;
                state_d = CONVERT;
            end else if (edgeCnt_d < HOLD_EDGE) begin
                state_d = ACQUIRE;
            end
            dout_d = bitNext;
        end
    end

    // Bit for the edge about to be counted; the hold lands before edge five reads it.
    always_comb begin
        bitNext = 1'b0;
        if (edgeInc >= A_FIRST_EDGE && edgeInc <= A_LAST_EDGE) begin
            bitNext = held_q.chanA[4'(A_LAST_EDGE - edgeInc)];
        end else if (edgeInc >= B_FIRST_EDGE) begin
            bitNext = held_q.chanB[4'(EDGES_PER_CONV - edgeInc)];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q   <= IDLE;
            edgeCnt_q <= NO_EDGE;
            track_q   <= '0;
            held_q    <= '0;
            oenN_q    <= 1'b1;
            dout_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            edgeCnt_q <= edgeCnt_d;
            track_q   <= track_d;
            held_q    <= held_d;
            oenN_q    <= oenN_d;
            dout_q    <= dout_d;
        end
    end

    // Ready is the buffer's registered not-full flag itself, so a word is taken
    // exactly on an edge where valid meets ready and none is lost or doubled.
    assign sampleReady = fifoReady;
    assign dout        = dout_q;
    assign doutOenN    = oenN_q;

    // ********************************************************************
    // Checks.
    // ********************************************************************
    AST_OEN_RELEASE: assert property (@(posedge core_clk) disable iff (srst)
        csHigh |=> oenN_q)
        else $error("Output driven while chip select high.");

    AST_OEN_DRIVE: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE) |-> !oenN_q)
        else $error("Output released during a frame.");

    AST_ABORT: assert property (@(posedge core_clk) disable iff (srst)
        (csHigh && state_q != IDLE) |=> (state_q == IDLE) && (edgeCnt_q == NO_EDGE))
        else $error("Frame not abandoned on chip select rise.");

    AST_WRAP: assert property (@(posedge core_clk) disable iff (srst)
        (!csHigh && state_q != IDLE && sclkFall && edgeCnt_q == EDGES_PER_CONV)
        |=> (edgeCnt_q == FIRST_EDGE) && (state_q == ACQUIRE))
        else $error("Conversion did not restart after edge thirty-two.");

    AST_FIRST_LOW: assert property (@(posedge core_clk) disable iff (srst)
        (state_q == IDLE && !csHigh && csFall && !sclkS2_q) |=> edgeCnt_q == FIRST_EDGE)
        else $error("Chip select fall with low clock not counted as edge one.");

    AST_LEAD_ZERO: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && edgeCnt_q >= FIRST_EDGE && edgeCnt_q < A_FIRST_EDGE) |-> !dout_q)
        else $error("Leading bit not zero.");

    AST_GAP_ZERO: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && edgeCnt_q >= GAP_FIRST_EDGE && edgeCnt_q <= GAP_LAST_EDGE)
        |-> !dout_q)
        else $error("Gap bit between channels not zero.");

    AST_MSB_A: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && edgeCnt_q == A_FIRST_EDGE && $changed(edgeCnt_q))
        |-> dout_q == held_q.chanA[CODE_W-1])
        else $error("Channel A most significant bit not first.");

    AST_LSB_B: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && edgeCnt_q == EDGES_PER_CONV) |-> dout_q == held_q.chanB[0])
        else $error("Channel B last bit wrong.");

    AST_HOLD: assert property (@(posedge core_clk) disable iff (srst)
        (state_q == ACQUIRE && !csHigh && sclkFall && edgeCnt_q == 6'd3)
        |=> (held_q == $past(codeNow)) && (state_q == CONVERT))
        else $error("Both channels not held on edge four.");

    AST_NO_LATENCY: assert property (@(posedge core_clk) disable iff (srst)
        (state_q == CONVERT && $past(state_q) == CONVERT) |-> $stable(held_q))
        else $error("Held result changed during its own readout.");

    AST_TRACK: assert property (@(posedge core_clk) disable iff (srst)
        (state_q == ACQUIRE && fifoOutValid) |=> track_q == $past(fifoOut))
        else $error("Input not tracked during acquisition.");

    AST_POS_FULL: assert property (@(posedge core_clk) disable iff (srst)
        (track_q.chanA >= 14'sd4093) |-> codeNow.chanA == 12'sh7FF)
        else $error("Positive full scale not reached.");

    AST_NEG_FULL: assert property (@(posedge core_clk) disable iff (srst)
        (track_q.chanB <= -14'sd4095) |-> codeNow.chanB == -12'sh800)
        else $error("Negative full scale not reached.");

    AST_POS_FULL_B: assert property (@(posedge core_clk) disable iff (srst)
        (track_q.chanB >= 14'sd4093) |-> codeNow.chanB == 12'sh7FF)
        else $error("Positive full scale not reached on channel B.");

    AST_NEG_FULL_A: assert property (@(posedge core_clk) disable iff (srst)
        (track_q.chanA <= -14'sd4095) |-> codeNow.chanA == -12'sh800)
        else $error("Negative full scale not reached on channel A.");

    AST_STEP: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && !csHigh && sclkFall && edgeCnt_q != EDGES_PER_CONV)
        |=> edgeCnt_q == 6'($past(edgeCnt_q) + 6'h1))
        else $error("Edge count did not advance by one.");

    AST_QUIET: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && !csHigh && !sclkFall) |=> $stable(edgeCnt_q) && $stable(dout_q))
        else $error("Output bit moved without a falling clock edge.");

    AST_ACQ_PHASE: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && edgeCnt_q < HOLD_EDGE) |-> state_q == ACQUIRE)
        else $error("Not tracking before the hold edge.");

    AST_CONV_PHASE: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && edgeCnt_q >= HOLD_EDGE) |-> state_q == CONVERT)
        else $error("Not converting after the hold edge.");

    AST_IDLE_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
        (state_q == IDLE) |-> (edgeCnt_q == NO_EDGE) && oenN_q && !dout_q)
        else $error("Idle state with live count or driven output.");

    AST_FROZEN_TRACK: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != ACQUIRE) |=> $stable(track_q))
        else $error("Tracked input moved outside acquisition.");

    AST_A_BITS: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && edgeCnt_q >= A_FIRST_EDGE && edgeCnt_q <= A_LAST_EDGE)
        |-> dout_q == held_q.chanA[4'(A_LAST_EDGE - edgeCnt_q)])
        else $error("Channel A bit out of place.");

    AST_B_BITS: assert property (@(posedge core_clk) disable iff (srst)
        (state_q != IDLE && edgeCnt_q >= B_FIRST_EDGE)
        |-> dout_q == held_q.chanB[4'(EDGES_PER_CONV - edgeCnt_q)])
        else $error("Channel B bit out of place.");

    COV_FULL_CONV: cover property (@(posedge core_clk) disable iff (srst)
        state_q != IDLE && edgeCnt_q == EDGES_PER_CONV);
    COV_BACK_TO_BACK: cover property (@(posedge core_clk) disable iff (srst)
        edgeCnt_q == EDGES_PER_CONV ##[1:20] edgeCnt_q == FIRST_EDGE && state_q == ACQUIRE);
    COV_ABORT: cover property (@(posedge core_clk) disable iff (srst)
        state_q == CONVERT && edgeCnt_q < A_LAST_EDGE && csHigh);
    COV_FIFO_FULL: cover property (@(posedge core_clk) disable iff (srst)
        !fifoReady);
    COV_START_LOW: cover property (@(posedge core_clk) disable iff (srst)
        state_q == IDLE && csFall && !sclkS2_q);

endmodule : dual_sample_serial_readout

/* File: verif/host_model.sv */
// Host-side model that frames conversions and captures the serial result bits.
`timescale 1ns/100ps
module host_model (
    output logic      csN,
    output logic      sclk,
    input  wire logic dout,
    input  wire logic doutOenN
);
    // ****************************************************************
    // Frame driver and bit capture.
    // ****************************************************************
    logic bitQ[$];
    int   enErr;

    initial begin
        csN   = 1'b1;
        sclk  = 1'b1;
        enErr = 0;
    end

    // The clock stands high between frames, except that a low-start frame drops it 400 ns before chip select falls.
    // Bits are taken on the rising edge, half a period after the launching fall.
    task automatic run_frame(input int nEdges, input int abortAt, input bit startLow);
        bitQ.delete();
        #37;
        if (startLow) begin
            sclk = 1'b0;
            #400;
        end
        csN = 1'b0;
        #1000;
        for (int k = 1; k <= nEdges; k++) begin
            if (k > 1 || !startLow) begin
                sclk = 1'b0;
                #400;
            end
            sclk = 1'b1;
            bitQ.push_back(dout);
            if (doutOenN !== 1'b0) enErr++;
            if (k == abortAt) break;
            #400;
        end
        #200;
        csN = 1'b1;
        #300;
    endtask : run_frame
endmodule : host_model

/* File: verif/dual_sample_serial_readout_tb_top.sv */
// Self-checking testbench of the dual-channel serial readout block.
`timescale 1ns/100ps
module dual_sample_serial_readout_tb_top;
    import dual_readout_pkg::*;

    // ****************************************************************
    // Stimulus, reference model and checks.
    // ****************************************************************
    logic                    core_clk = 1'b0;
    logic                    srst     = 1'b1;
    logic                    csN;
    logic                    sclk;
    logic signed [RAW_W-1:0] rawA     = '0;
    logic signed [RAW_W-1:0] rawB     = '0;
    logic                    sampleValid = 1'b0;
    logic                    sampleReady;
    logic                    dout;
    logic                    doutOenN;
    int                      seed     = 38;
    int                      errors   = 0;
    int                      n_tests  = 0;
    int                      cycles   = 0;
    int                      lastA    = 0;
    int                      lastB    = 0;
    int                      tbl[7]   = '{4093, 4092, -4096, -4095, 0, -2, 8191};

    always #50 core_clk = ~core_clk;

    dual_sample_serial_readout DUT (
        .core_clk          (core_clk),
        .srst              (srst),
        .csN               (csN),
        .sclk              (sclk),
        .diff_input_chan_a (rawA),
        .diff_input_chan_b (rawB),
        .sampleValid       (sampleValid),
        .sampleReady       (sampleReady),
        .dout              (dout),
        .doutOenN          (doutOenN)
    );

    host_model host (
        .csN      (csN),
        .sclk     (sclk),
        .dout     (dout),
        .doutOenN (doutOenN)
    );

    task automatic check(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    // Half-step input units are rounded and clamped to the 12-bit range.
    function automatic logic [11:0] code12(input int raw);
        int c;
        c = (raw + 1) >>> 1;
        if (c > 2047) c = 2047;
        if (raw <= -4095) c = -2048;
        return c[11:0];
    endfunction : code12

    function automatic logic exp_bit(input int k, input logic [11:0] a, input logic [11:0] b);
        if (k >= 5 && k <= 16) return a[16-k];
        if (k >= 21) return b[32-k];
        return 1'b0;
    endfunction : exp_bit

    // With valid held the buffer refills, so the pair tracked is the one just set.
    task automatic do_frame(input int a, input int b, input int nConv, input int abortAt,
                            input bit startLow, input bit feed);
        int          n;
        logic [11:0] ca;
        logic [11:0] cb;
        @(posedge core_clk);
        rawA        <= a[RAW_W-1:0];
        rawB        <= b[RAW_W-1:0];
        sampleValid <= feed;
        if (feed) begin
            lastA = $signed(a[RAW_W-1:0]);
            lastB = $signed(b[RAW_W-1:0]);
        end
        ca = code12(lastA);
        cb = code12(lastB);
        repeat (30) @(posedge core_clk);
        if (feed) check(sampleReady === 1'b0, "buffer did not refuse when full");
        host.run_frame(nConv * 32, abortAt, startLow);
        n = host.bitQ.size();
        check(n == ((abortAt > 0) ? abortAt : nConv * 32), "captured bit count");
        for (int i = 0; i < n; i++) begin
            check(host.bitQ[i] === exp_bit((i % 32) + 1, ca, cb), "serial bit");
        end
        check(host.enErr == 0, "output released inside frame");
        check(doutOenN === 1'b1 && dout === 1'b0, "output not released");
    endtask : do_frame

    task automatic give_verdict();
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(doutOenN === 1'b1 && dout === 1'b0, "output driven after reset");
        for (int i = 0; i < 7; i++) begin
            do_frame(tbl[i], tbl[6-i], 1, 0, i[0], 1'b1);
        end
        for (int i = 0; i < 3; i++) begin
            do_frame($random(seed), $random(seed), 1, 0, i[0], 1'b1);
        end
        do_frame($random(seed), $random(seed), 2, 0, 1'b0, 1'b1);
        do_frame(1000, -1000, 1, 10, 1'b0, 1'b1);
        do_frame(-3000, 3000, 1, 0, 1'b0, 1'b1);
        do_frame(0, 0, 1, 0, 1'b0, 1'b0);
        check(sampleReady === 1'b1, "buffer not drained by acquisition");
        give_verdict();
    end
endmodule : dual_sample_serial_readout_tb_top
